/* File: hdl/ubr_map.svh */
// Constants for the serial channel data path and input routing
`ifndef UBR_MAP_SVH
`define UBR_MAP_SVH
`define UBR_BUF_RESET 8'hff
`define UBR_ISC_RX0_TO_TMRA 1
`define UBR_ISC_RX1_TO_TMRB 2
`define UBR_ISC_TMRA_ALT 5
`define UBR_ISC_TMRB_ALT 6
`define UBR_ISC_RX0_ALT 7
`define UBR_BAUD_DIV 16'd4
`define UBR_CHAR7_BITS 4'd7
`define UBR_CHAR8_BITS 4'd8
`endif

/* File: hdl/ubr_pkg.sv */
// Types for the serial channel data path
package ubr_pkg;
  typedef logic [7:0] ubr_byte_t;
  typedef enum logic [1:0] {
    UBR_IDLE = 2'b00,
    UBR_START = 2'b01,
    UBR_DATA = 2'b10,
    UBR_STOP = 2'b11
  } ubr_state_e;
endpackage : ubr_pkg

/* File: hdl/ubr_place_if.sv */
// Carrier between the receive placer and the top
`timescale 1ns/1ns
interface ubr_place_if;
  logic [7:0] raw;
  logic char8;
  logic msb_first;
  logic [7:0] placed;
  modport top (output raw, output char8, output msb_first, input placed);
  modport placer (input raw, input char8, input msb_first, output placed);
endinterface : ubr_place_if

/* File: hdl/ubr_rx_place.sv */
// Placement of received characters into buffer bit positions
`timescale 1ns/1ns
module ubr_rx_place (
  // Carrier
  ubr_place_if.placer p
);
  // ==========================================================
  // Placement
  wire [7:0] lsb7 = {1'b0, p.raw[6:0]};
  wire [7:0] msb7 = {p.raw[6:0], 1'b0};
  wire [7:0] sel7 = p.msb_first ? msb7 : lsb7;
  assign p.placed = p.char8 ? p.raw : sel7;
endmodule : ubr_rx_place

/* File: hdl/ubr_top.sv */
// Serial channel buffers, shifters and LIN input routing
//
// Summary of operation
// - INPUT_ROUTE_SELECT_REG bit7 picks rx0 pin: port1 or port7
// - Timer A: rx0 if bit1, else bit5 pin
// - Timer B: rx1 if bit2, else bit6 pin
// - Shift serial in, copy each character to buffer unless it overruns
// - 7-bit LSB-first: bits 0-6, bit7 zero
// - 7-bit MSB-first: bits 1-7, bit0 zero
// - Overrun keeps the old receive buffer
// - Receive buffer byte read only, writes ignored
// - Both buffers reset to all ones
// - Transmit buffer read/write; write starts sending
// - Shifter loads on the next tick while idle, or at the end of the stop bit
// - Transfer and output on base clock falling edge
// - Shifters not reachable from the bus
// - Edge on routed rx flags wakeup
// - Length bit: 0 seven bits, 1 eight
// - Selectable LSB-first or MSB-first order
// - Operation enable low resets receive buffer, full, overrun and transmit/receive complete irq flags; wake edge irqs keep running
`timescale 1ns/1ns
`include "ubr_map.svh"
module ubr_top (
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_ce,
  // Channel control
  input wire logic i_unit_operation_enable,
  input wire logic i_transmit_enable_bit,
  input wire logic i_receive_enable_bit,
  input wire logic i_char_length_bit,
  input wire logic i_msb_first,
  input wire logic [7:0] i_input_route_select_reg,
  // Byte access
  input wire logic i_txb_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_rxb_wr,
  // Pins
  input wire logic i_rx0_port1_pin,
  input wire logic i_rx0_port7_pin,
  input wire logic i_timer_a_io_pin,
  input wire logic i_timer_a_alt_pin,
  input wire logic i_rx1_pin,
  input wire logic i_timer_b_io_pin,
  input wire logic i_timer_b_alt_pin,
  // Outputs
  output logic [7:0] o_receive_data_buffer,
  output logic [7:0] o_transmit_data_buffer,
  output logic o_tx_buffer_full_flag,
  output logic o_overrun_error_flag,
  output logic o_tx_complete_irq,
  output logic o_rx_complete_irq,
  output logic o_serial_out_pin,
  output logic o_capture_timer_a_in,
  output logic o_capture_timer_b_in,
  output logic o_wake_edge_irq_ch0,
  output logic o_wake_edge_irq_ch1
);
  // ==========================================================
  // Pin synchronisers
  logic [6:0] sync1;
  logic [6:0] sync2;
  wire [6:0] pins = {i_timer_b_alt_pin, i_timer_b_io_pin, i_rx1_pin, i_timer_a_alt_pin,
                     i_timer_a_io_pin, i_rx0_port7_pin, i_rx0_port1_pin};
  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : g_sync
      always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
          sync1[g] <= 1'b1;
          sync2[g] <= 1'b1;
        end else if (i_ce) begin
          sync1[g] <= pins[g];
          sync2[g] <= sync1[g];
        end
      end
    end
  endgenerate
  // ==========================================================
  // Input routing
  wire [7:0] input_route_select_reg = i_input_route_select_reg;
  wire rx0_raw = input_route_select_reg[`UBR_ISC_RX0_ALT] ? sync2[1] : sync2[0];
  wire tmra_pin = input_route_select_reg[`UBR_ISC_TMRA_ALT] ? sync2[3] : sync2[2];
  wire tmra_sel = input_route_select_reg[`UBR_ISC_RX0_TO_TMRA] ? rx0_raw : tmra_pin;
  wire tmrb_pin = input_route_select_reg[`UBR_ISC_TMRB_ALT] ? sync2[6] : sync2[5];
  wire tmrb_sel = input_route_select_reg[`UBR_ISC_RX1_TO_TMRB] ? sync2[4] : tmrb_pin;
  // Receive input reads high while the unit is off
  wire rx_line = i_unit_operation_enable ? rx0_raw : 1'b1;
  logic rx0_prev;
  logic rx1_prev;
  wire wake0 = rx0_prev ^ rx0_raw;
  wire wake1 = rx1_prev ^ sync2[4];
  // ==========================================================
  // Base clock divider; a fall event is one tick of it
  logic [15:0] div;
  wire tick = (div == `UBR_BAUD_DIV - 16'd1);
  wire [15:0] next_div = tick ? 16'd0 : div + 16'd1;
  wire run = i_unit_operation_enable;
  // ==========================================================
  // Receiver
  ubr_pkg::ubr_state_e rx_st;
  logic [7:0] receive_shifter;
  logic [3:0] rx_cnt;
  logic rx_unread;
  wire [3:0] nbits = i_char_length_bit ? `UBR_CHAR8_BITS : `UBR_CHAR7_BITS;
  wire rx_en = run && i_receive_enable_bit;
  wire rx_last = rx_st == ubr_pkg::UBR_DATA && rx_cnt == nbits - 4'd1;
  wire [7:0] lsb_shift = {rx_line, receive_shifter[7:1]};
  wire [7:0] msb_shift = {receive_shifter[6:0], rx_line};
  wire [7:0] rx_next = i_msb_first ? msb_shift : lsb_shift;
  wire [7:0] lsb_align = i_char_length_bit ? lsb_shift : {1'b0, lsb_shift[7:1]};
  wire [7:0] rx_aligned = i_msb_first ? msb_shift : lsb_align;
  wire rx_done = tick && rx_st == ubr_pkg::UBR_STOP && rx_line;
  wire overrun = rx_done && rx_unread;
  ubr_place_if place ();
  assign place.raw = receive_shifter;
  assign place.char8 = i_char_length_bit;
  assign place.msb_first = i_msb_first;
  ubr_rx_place u_place (.p(place));
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_st <= ubr_pkg::UBR_IDLE;
      receive_shifter <= `UBR_BUF_RESET;
      rx_cnt <= 4'd0;
    end else if (i_ce && (!rx_en)) begin
      rx_st <= ubr_pkg::UBR_IDLE;
      rx_cnt <= 4'd0;
    end else if (i_ce && tick) begin
      case (rx_st)
        ubr_pkg::UBR_IDLE: begin
          if (!rx_line) rx_st <= ubr_pkg::UBR_DATA;
          rx_cnt <= 4'd0;
        end
        ubr_pkg::UBR_DATA: begin
          receive_shifter <= rx_last ? rx_aligned : rx_next;
          rx_cnt <= rx_cnt + 4'd1;
          if (rx_last) rx_st <= ubr_pkg::UBR_STOP;
        end
        ubr_pkg::UBR_STOP: rx_st <= ubr_pkg::UBR_IDLE;
        default: rx_st <= ubr_pkg::UBR_IDLE;
      endcase
    end
  end
  // Receive buffer and receive flags cleared while the unit is off
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_receive_data_buffer <= `UBR_BUF_RESET;
      o_overrun_error_flag <= 1'b0;
      o_rx_complete_irq <= 1'b0;
      rx_unread <= 1'b0;
    end else if (i_ce && !run) begin
      o_receive_data_buffer <= `UBR_BUF_RESET;
      o_overrun_error_flag <= 1'b0;
      o_rx_complete_irq <= 1'b0;
      rx_unread <= 1'b0;
    end else if (i_ce) begin
      o_rx_complete_irq <= rx_done;
      o_overrun_error_flag <= overrun | (o_overrun_error_flag & ~rx_done);
      // Bus writes to the receive buffer are dropped here
      if (rx_done && !overrun) o_receive_data_buffer <= place.placed;
      // A character arriving with the read acknowledge overruns if one is unread; the acknowledge wins
      rx_unread <= (rx_done && !overrun) | (rx_unread & ~i_rxb_wr);
    end
  end
  // ==========================================================
  // Transmitter
  ubr_pkg::ubr_state_e tx_st;
  logic [7:0] transmit_shifter;
  logic [3:0] tx_cnt;
  wire tx_en = run && i_transmit_enable_bit;
  wire tx_load = tick && o_tx_buffer_full_flag && (tx_st == ubr_pkg::UBR_IDLE ||
                 tx_st == ubr_pkg::UBR_STOP);
  wire tx_data_last = tx_st == ubr_pkg::UBR_DATA && tx_cnt == nbits - 4'd1;
  wire tx_bit = i_msb_first ? transmit_shifter[7] : transmit_shifter[0];
  wire [7:0] tx_shift = i_msb_first ? {transmit_shifter[6:0], 1'b1} : {1'b1, transmit_shifter[7:1]};
  wire [7:0] tx_init = (!i_char_length_bit && i_msb_first) ? {o_transmit_data_buffer[6:0], 1'b1}
                       : o_transmit_data_buffer;
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_transmit_data_buffer <= `UBR_BUF_RESET;
      o_tx_buffer_full_flag <= 1'b0;
    end else if (i_ce && !run) begin
      o_tx_buffer_full_flag <= 1'b0;
    end else if (i_ce) begin
      if (i_txb_wr && tx_en) o_transmit_data_buffer <= i_wdata;
      // Write sets, load clears; set wins
      o_tx_buffer_full_flag <= (i_txb_wr && tx_en) | (o_tx_buffer_full_flag & ~tx_load);
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_st <= ubr_pkg::UBR_IDLE;
      transmit_shifter <= `UBR_BUF_RESET;
      tx_cnt <= 4'd0;
      o_serial_out_pin <= 1'b1;
      o_tx_complete_irq <= 1'b0;
    end else if (i_ce && !tx_en) begin
      tx_st <= ubr_pkg::UBR_IDLE;
      tx_cnt <= 4'd0;
      o_serial_out_pin <= 1'b1;
      o_tx_complete_irq <= 1'b0;
    end else if (i_ce) begin
      o_tx_complete_irq <= tick && tx_st == ubr_pkg::UBR_STOP;
      if (tx_load) begin
        transmit_shifter <= tx_init;
        tx_st <= ubr_pkg::UBR_START;
        o_serial_out_pin <= 1'b0;
      end else if (tick) begin
        case (tx_st)
          ubr_pkg::UBR_START: begin
            tx_st <= ubr_pkg::UBR_DATA;
            tx_cnt <= 4'd0;
            o_serial_out_pin <= tx_bit;
            transmit_shifter <= tx_shift;
          end
          ubr_pkg::UBR_DATA: begin
            tx_cnt <= tx_cnt + 4'd1;
            o_serial_out_pin <= tx_data_last ? 1'b1 : tx_bit;
            transmit_shifter <= tx_shift;
            if (tx_data_last) tx_st <= ubr_pkg::UBR_STOP;
          end
          ubr_pkg::UBR_STOP: tx_st <= ubr_pkg::UBR_IDLE;
          ubr_pkg::UBR_IDLE: o_serial_out_pin <= 1'b1;
          default: tx_st <= ubr_pkg::UBR_IDLE;
        endcase
      end
    end
  end
  // ==========================================================
  // Divider, routing outputs, wake edges
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div <= 16'd0;
      rx0_prev <= 1'b1;
      rx1_prev <= 1'b1;
      o_capture_timer_a_in <= 1'b1;
      o_capture_timer_b_in <= 1'b1;
      o_wake_edge_irq_ch0 <= 1'b0;
      o_wake_edge_irq_ch1 <= 1'b0;
    end else if (i_ce) begin
      div <= run ? next_div : 16'd0;
      rx0_prev <= rx0_raw;
      rx1_prev <= sync2[4];
      o_capture_timer_a_in <= tmra_sel;
      o_capture_timer_b_in <= tmrb_sel;
      o_wake_edge_irq_ch0 <= wake0;
      o_wake_edge_irq_ch1 <= wake1;
    end
  end
endmodule : ubr_top

/* File: tb/ubr_props.sv */
// Checker for buffers, transmit hand-off and input routing
`timescale 1ns/1ns
module ubr_props (
  // Clock and controls
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_unit_operation_enable,
  input wire logic i_transmit_enable_bit,
  input wire logic [7:0] i_input_route_select_reg,
  input wire logic i_txb_wr,
  input wire logic [7:0] i_wdata,
  // Pins
  input wire logic i_rx0_port1_pin,
  input wire logic i_rx0_port7_pin,
  input wire logic i_timer_a_io_pin,
  input wire logic i_timer_a_alt_pin,
  input wire logic i_rx1_pin,
  input wire logic i_timer_b_io_pin,
  input wire logic i_timer_b_alt_pin,
  // Outputs
  input wire logic [7:0] o_receive_data_buffer,
  input wire logic [7:0] o_transmit_data_buffer,
  input wire logic o_tx_buffer_full_flag,
  input wire logic o_rx_complete_irq,
  input wire logic o_serial_out_pin,
  input wire logic o_capture_timer_a_in,
  input wire logic o_capture_timer_b_in,
  input wire logic o_wake_edge_irq_ch0
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  // Cycles since reset; pin synchronisers hold ones until then
  logic [2:0] up;
  wire logic [7:0] input_route_select_reg = i_input_route_select_reg;
  wire logic rx0 = input_route_select_reg[7] ? i_rx0_port7_pin : i_rx0_port1_pin;
  wire logic ea = input_route_select_reg[1] ? rx0 : (input_route_select_reg[5] ? i_timer_a_alt_pin : i_timer_a_io_pin);
  wire logic eb = input_route_select_reg[2] ? i_rx1_pin : (input_route_select_reg[6] ? i_timer_b_alt_pin : i_timer_b_io_pin);
  wire logic txon = i_unit_operation_enable && i_transmit_enable_bit;
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      up <= 3'h0;
    end else if (up != 3'h7) begin
      up <= up + 3'h1;
    end
  end
  reset_ones_a: assert property (
    $rose(i_reset_n) |-> o_receive_data_buffer == 8'hff && o_transmit_data_buffer == 8'hff)
    else $error("buffers not ones after reset");
  rx_hold_a: assert property (
    !$stable(o_receive_data_buffer) |-> (!i_unit_operation_enable || !$past(i_unit_operation_enable))
      or (##[0:1] o_rx_complete_irq)) else $error("rx buffer changed without a character");
  unit_off_a: assert property (
    !i_unit_operation_enable && i_ce |=> o_receive_data_buffer == 8'hff && !o_tx_buffer_full_flag)
    else $error("unit off did not clear");
  full_set_a: assert property (
    i_txb_wr && txon |=> o_tx_buffer_full_flag && o_transmit_data_buffer == $past(i_wdata))
    else $error("tx write not taken");
  full_clear_a: assert property (
    o_tx_buffer_full_flag && txon |-> ##[0:48] !o_tx_buffer_full_flag) else $error("shifter never loaded");
  start_bit_a: assert property (
    $fell(o_tx_buffer_full_flag) && txon && $past(txon) |-> !o_serial_out_pin) else $error("no start bit");
  route_a_a: assert property (
    ($stable(input_route_select_reg) && up == 3'h7) [*3] |-> o_capture_timer_a_in == $past(ea, 3)) else $error("timer a route");
  route_b_a: assert property (
    ($stable(input_route_select_reg) && up == 3'h7) [*3] |-> o_capture_timer_b_in == $past(eb, 3)) else $error("timer b route");
  wake_edge_a: assert property (
    o_wake_edge_irq_ch0 && up == 3'h7 && $past(input_route_select_reg[7], 5) == input_route_select_reg[7] |-> $past(rx0, 2) != $past(rx0, 3)
      || $past(rx0, 3) != $past(rx0, 4) || $past(rx0, 4) != $past(rx0, 5)) else $error("wake without edge");
endmodule : ubr_props
bind ubr_top ubr_props u_props (.*);

/* File: tb/ubr_remote.sv */
// Remote serial node: sends frames on rx, decodes frames from tx
`timescale 1ns/1ns
module ubr_remote (
  // Clock and line
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_line
);
  // Line idles high, as the transceiver pull-up leaves it
  initial o_line = 1'b1;
  task automatic send(input logic [7:0] d, input int n, input logic m);
    for (int i = -1; i <= n; i++) begin
      @(posedge i_clk);
      #1;
      o_line = (i < 0) ? 1'b0 : (i == n) ? 1'b1 : d[m ? n - 1 - i : i];
      repeat (3) @(posedge i_clk);
    end
  endtask : send
  // Samples mid-bit, so a one-clock skew still decodes
  task automatic recv(input int n, input logic m, output logic [7:0] r);
    r = 8'h00;
    @(negedge i_line);
    repeat (2) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge i_clk);
      r = m ? {r[6:0], i_line} : {i_line, r[7:1]};
    end
  endtask : recv
endmodule : ubr_remote

/* File: tb/tb_ubr_top.sv */
// Self-checking bench for the serial channel block
`timescale 1ns/1ns
module tb_ubr_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic unit = 1'b0, txe = 1'b0, rxe = 1'b0, cl = 1'b1, msb = 1'b0, wr = 1'b0, rwr = 1'b0, rmode = 1'b1;
  logic [7:0] input_route_select_reg = 8'h00, wd = 8'h00, got;
  logic [6:0] pins = 7'h7f;
  logic [15:0] seed = 16'hbc60;
  logic ce = 1'b1;
  int error_cnt = 0, comparisons = 0, cyc = 0, tc_cnt = 0, w1_cnt = 0, w1_exp = 0;
  wire logic [7:0] rbuf, tbuf;
  wire logic rline, full, ovr, sout, ta, tb, rirq, tcirq, w1;
  wire logic p1 = rmode ? pins[6] : rline;
  ubr_top u_dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_ce(ce), .i_unit_operation_enable(unit),
    .i_transmit_enable_bit(txe), .i_receive_enable_bit(rxe), .i_char_length_bit(cl), .i_msb_first(msb),
    .i_input_route_select_reg(input_route_select_reg), .i_txb_wr(wr), .i_wdata(wd), .i_rxb_wr(rwr), .i_rx0_port1_pin(p1),
    .i_rx0_port7_pin(pins[0]), .i_timer_a_io_pin(pins[1]), .i_timer_a_alt_pin(pins[2]), .i_rx1_pin(pins[3]),
    .i_timer_b_io_pin(pins[4]), .i_timer_b_alt_pin(pins[5]), .o_receive_data_buffer(rbuf),
    .o_transmit_data_buffer(tbuf), .o_tx_buffer_full_flag(full), .o_overrun_error_flag(ovr),
    .o_tx_complete_irq(tcirq), .o_rx_complete_irq(rirq), .o_serial_out_pin(sout), .o_capture_timer_a_in(ta),
    .o_capture_timer_b_in(tb), .o_wake_edge_irq_ch0(), .o_wake_edge_irq_ch1(w1));
  ubr_remote u_remote (.i_clk(clk), .i_line(sout), .o_line(rline));
  always #20 clk = ~clk;
  // ==========
  // Helpers
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt
  function automatic logic [1:0] route(input logic [7:0] s, input logic [6:0] p);
    logic r0;
    r0 = s[7] ? p[0] : p[6];
    return {s[1] ? r0 : (s[5] ? p[2] : p[1]), s[2] ? p[3] : (s[6] ? p[5] : p[4])};
  endfunction : route
  function automatic logic [7:0] exp_rx(input logic [7:0] d, input logic c8, input logic m);
    return c8 ? d : (m ? {d[6:0], 1'b0} : {1'b0, d[6:0]});
  endfunction : exp_rx
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  task automatic rx_char(input logic [7:0] d, input logic c8, input logic m, input logic ack);
    int t;
    t = 0;
    cl = c8;
    msb = m;
    fork
      u_remote.send(d, c8 ? 8 : 7, m);
      while (!rirq && t < 200) begin
        step(1);
        t++;
      end
    join
    wd = ~d;
    rwr = ack;
    step(1);
    rwr = 1'b0;
  endtask : rx_char
  always @(posedge clk) begin
    cyc++;
    if (tcirq === 1'b1) tc_cnt++;
    if (w1 === 1'b1) w1_cnt++;
    if (cyc == 5000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // ==========
  // Main sequence
  initial begin
    step(10);
    rst_n = 1'b1;
    check(rbuf, 8'hff);
    check(tbuf, 8'hff);
    for (int k = 0; k < 40; k++) begin
      seed = nxt(seed);
      input_route_select_reg = seed[15:8];
      w1_exp += (seed[3] != pins[3]) ? 1 : 0;
      pins = seed[6:0];
      step(5);
      check({6'h00, ta, tb}, {6'h00, route(input_route_select_reg, pins)});
    end
    check(w1_cnt[7:0], w1_exp[7:0]);
    rmode = 1'b0;
    input_route_select_reg = 8'h00;
    unit = 1'b1;
    step(1);
    rxe = 1'b1;
    txe = 1'b1;
    step(4);
    for (int k = 0; k < 4; k++) begin
      seed = nxt(seed);
      rx_char(seed[7:0], k[1], k[0], 1'b1);
      check(rbuf, exp_rx(seed[7:0], k[1], k[0]));
    end
    rx_char(8'h5a, 1'b1, 1'b0, 1'b0);
    rx_char(8'hc3, 1'b1, 1'b0, 1'b1);
    check({7'h00, ovr}, 8'h01);
    check(rbuf, 8'h5a);
    rx_char(8'h3c, 1'b1, 1'b1, 1'b1);
    check(rbuf, 8'h3c);
    for (int k = 0; k < 4; k++) begin
      seed = nxt(seed);
      msb = k[0];
      wd = seed[7:0];
      fork
        u_remote.recv(8, msb, got);
        begin
          wr = 1'b1;
          step(1);
          wr = 1'b0;
          check({7'h00, full}, 8'h01);
          check(tbuf, wd);
        end
      join
      check(got, wd);
      step(8);
    end
    check(tc_cnt[7:0], 8'h04);
    ce = 1'b0;
    unit = 1'b0;
    step(3);
    check(rbuf, 8'h3c);
    ce = 1'b1;
    step(2);
    check(rbuf, 8'hff);
    check({7'h00, full}, 8'h00);
    wrap_up();
  end
endmodule : tb_ubr_top
